// File: lcs_pkg.sv
`default_nettype none
package lcs_pkg;
  // AHB byte addresses of the directly reached registers
  localparam logic [7:0] A_CFG   = 8'h00;
  localparam logic [7:0] A_PTR   = 8'h04;
  localparam logic [7:0] A_WIN   = 8'h08;
  localparam logic [7:0] A_ISTAT = 8'h0C;
  localparam logic [7:0] A_ICLR  = 8'h10;
  localparam logic [7:0] A_IEN   = 8'h14;
  localparam logic [7:0] A_NONE  = 8'hFF;
  // Role configuration fields
  localparam int CFG_EN    = 7;
  localparam int CFG_MST   = 6;
  localparam int CFG_AUTO  = 5;
  localparam int CFG_CLKOK = 0;
  localparam logic [2:0] CFG_RST = 3'h0;
  // Indirect register indices
  localparam logic [7:0] I_DATA_TOP = 8'h07;
  localparam logic [7:0] I_CTRL = 8'h08;
  localparam logic [7:0] I_ST   = 8'h09;
  localparam logic [7:0] I_ERR  = 8'h0A;
  localparam logic [7:0] I_SIZE = 8'h0B;
  localparam logic [7:0] I_DIV  = 8'h0C;
  localparam logic [7:0] I_MUL  = 8'h0D;
  localparam logic [7:0] I_ID   = 8'h0E;
  localparam int CT_STREQ  = 0;
  localparam int CT_RSTERR = 2;
  localparam int CT_RSTINT = 3;
  localparam int CT_TXRX   = 5;
  localparam int ST_DONE = 0;
  localparam int ST_ERR  = 2;
  localparam int ST_ACT  = 7;
  localparam int E_BIT = 0;
  localparam int E_CKS = 1;
  localparam int E_PAR = 2;
  localparam int E_TMO = 3;
  localparam int E_SYN = 4;
  localparam int SZ_ENH = 7;
  localparam logic [3:0] SZ_DECODE = 4'hF;
  localparam logic [3:0] SZ_MAX    = 4'h8;
  localparam logic [7:0] SIZE_RST = 8'h00;
  localparam logic [7:0] DIV_RST  = 8'h00;
  localparam logic [7:0] MUL_RST  = 8'h00;
  localparam int IS_DONE = 0;
  localparam int IS_ERR  = 1;
  // Frame timing in bit times
  localparam logic [3:0] BREAK_BITS   = 4'hD;
  localparam logic [3:0] BRK_MIN_BITS = 4'hB;
  localparam logic [3:0] TMO_BITS     = 4'hE;
  localparam logic [3:0] STOP_BIT     = 4'h9;
  localparam logic [7:0] SYNC_BYTE    = 8'h55;
  localparam logic [2:0] SYNC_FALLS   = 3'h5;
  localparam int MIN_CLK_HZ = 8_000_000;
  typedef enum {S_IDLE, S_MBRK, S_DELIM, S_SBRK, S_SYNC, S_START, S_BYTE}
    lcs_state_t;
endpackage : lcs_pkg
`default_nettype wire

// File: lcs_top.sv
// Overview of operation
// [RULE_01] Role bit 6 of direct config register picks master or slave node.
// [RULE_02] Bit 5 of that register picks manual or automatic baud rate.
// [RULE_03] Master always uses manual baud; autobaud only acts in slave role.
// [RULE_04] Role and autobaud bits direct; all else through pointer/window. Code also keeps the enable bit and the interrupt registers direct.
// [RULE_05] Pointer value picks which internal register the window reaches.
// [RULE_06] Hardware builds and checks classic or enhanced checksum as set.
// [RULE_07] Clock must be 8 MHz or more; slower is flagged unsupported.
// [RULE_08] Done and error status serve both interrupts and polling.
// [RULE_09] State machine serialises bytes and makes all bit timing.
// [RULE_10] Eight data registers hold bytes to send and bytes received.
// [RULE_11] Frame, header, checksum and errors follow LIN 2.1 for all nodes.
// [RULE_12] Slave autobaud measures sync field before sampling the rest.
`timescale 1ns/1ps
`default_nettype none
module lcs_top import lcs_pkg::*; #(
  parameter int CLK_HZ = 200_000_000
) (
  input  wire logic        CLK,       // System clock
  input  wire logic        NRST,      // Async reset, active low
  input  wire logic        HSEL,      // AHB select
  input  wire logic [31:0] HADDR,     // AHB address
  input  wire logic [1:0]  HTRANS,    // AHB transfer type
  input  wire logic        HWRITE,    // AHB write
  input  wire logic [2:0]  HSIZE,     // AHB size, words only
  input  wire logic [31:0] HWDATA,    // AHB write data
  input  wire logic        HREADY,    // AHB bus ready
  output logic      [31:0] HRDATA,    // AHB read data
  output logic             HREADYOUT, // AHB slave ready
  output logic             HRESP,     // AHB response, always OKAY
  input  wire logic        LIN_RX,    // Bus level from transceiver
  output logic             LIN_TX,    // Bus drive, low is dominant
  output logic             IRQ        // Level interrupt
);
  localparam logic CLK_OK = (CLK_HZ >= MIN_CLK_HZ); // RULE_07

  logic             rx_m_r, rx_s_r, rx_d_r;
  logic             wr_r;
  logic [7:0]       wa_r;
  logic [31:0]      rdata_nxt;
  logic [2:0]       cfg_r;
  logic [7:0]       ptr_r;
  logic [1:0]       ien_r, ist_r;
  logic [7:0]       data_r [0:7];
  logic [7:0]       size_r, div_r, mul_r;
  logic [5:0]       id_r;
  logic             txrx_r, done_r, err_r;
  logic [4:0]       errs_r;
  lcs_state_t       st_r;
  logic [23:0]      tmr_r;
  logic [3:0]       bcnt_r, idx_r;
  logic [7:0]       rsh_r, sum_r;
  logic [19:0]      meas_r;
  logic [2:0]       falls_r;

  // Bus line synchroniser; only rx_s_r and later are looked at
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rx_m_r <= 1'b1;
      rx_s_r <= 1'b1;
      rx_d_r <= 1'b1;
    end else begin
      rx_m_r <= LIN_RX;
      rx_s_r <= rx_m_r;
      rx_d_r <= rx_s_r;
    end
  end
  wire fall = rx_d_r & ~rx_s_r;

  // AHB slave: zero wait states, read data muxed in address phase
  wire acc = HSEL & HREADY & HTRANS[1];
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      wr_r      <= 1'b0;
      wa_r      <= A_NONE;
      HRDATA    <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      wr_r      <= acc & HWRITE;
      wa_r      <= (HADDR[31:8] == 24'h00_0000) ? HADDR[7:0] : A_NONE;
      HRDATA    <= (acc & ~HWRITE) ? rdata_nxt : 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
  end
  wire [7:0] wdat   = HWDATA[7:0];
  wire       win_we = wr_r & (wa_r == A_WIN);
  wire       ctl_we = win_we & (ptr_r == I_CTRL);
  wire       start_wr = ctl_we & wdat[CT_STREQ];
  wire       rst_err  = ctl_we & wdat[CT_RSTERR];
  wire       rst_int  = ctl_we & wdat[CT_RSTINT];

  wire cfg_en   = cfg_r[2];
  wire cfg_mst  = cfg_r[1];
  wire cfg_auto = cfg_r[0]; // RULE_02
  wire auto_eff = cfg_auto & ~cfg_mst; // RULE_03

  // Bit period in clocks
  wire [8:0]  div9 = {mul_r[0], div_r};
  wire [5:0]  mp1  = {1'b0, mul_r[5:1]} + 6'h01;
  wire [2:0]  psh  = {1'b0, mul_r[7:6]} + 3'h1;
  wire [19:0] bl_man = ({11'h000, div9} * {14'h0000, mp1}) << psh;
  wire [19:0] bl_nom = {11'h000, div9} << psh;
  logic [19:0] bl_use;
  always_comb begin
    if (!auto_eff)
      bl_use = bl_man;
    else if (st_r == S_SBRK || st_r == S_SYNC)
      bl_use = bl_nom; // Nominal rate from divider and prescaler only, no multiplier, until the sync is measured
    else
      bl_use = meas_r; // RULE_12
  end
  wire [23:0] bl24    = {4'h0, bl_use};
  wire        bit_end = (tmr_r == bl24 - 24'h00_0001);
  wire        mid     = (st_r == S_BYTE) & (tmr_r == (bl24 >> 1));

  // Data length, fixed or decoded from the identifier
  logic [3:0] nbytes;
  always_comb begin
    if (size_r[3:0] == SZ_DECODE) begin
      case (id_r[5:4])
        2'h2:    nbytes = 4'h4;
        2'h3:    nbytes = 4'h8;
        default: nbytes = 4'h2;
      endcase
    end else if (size_r[3:0] > SZ_MAX) begin
      nbytes = SZ_MAX;
    end else begin
      nbytes = size_r[3:0];
    end
  end
  wire [3:0] last = nbytes + 4'h2;

  function automatic logic [7:0] pid_of(input logic [5:0] i);
    logic p0, p1;
    p0 = i[0] ^ i[1] ^ i[2] ^ i[4];
    p1 = ~(i[1] ^ i[3] ^ i[4] ^ i[5]);
    return {p1, p0, i};
  endfunction : pid_of

  // Sum with end-around carry
  function automatic logic [7:0] cadd(input logic [7:0] a,
                                      input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[7:0] + {7'h00, s[8]};
  endfunction : cadd

  // Header bytes always go from the master, response per direction bit
  wire       tx_now = (idx_r < 4'h2) ? cfg_mst : txrx_r;
  wire [3:0] idx_nx = idx_r + 4'h1;
  wire       tx_nx  = (idx_nx < 4'h2) ? cfg_mst : txrx_r;
  wire [2:0] didx   = 3'(idx_r - 4'h2);
  wire [7:0] pid_tx = pid_of(id_r);
  wire [7:0] pid_rx = pid_of(rsh_r[5:0]);
  logic [7:0] cur_tx;
  always_comb begin
    if (idx_r == 4'h0)
      cur_tx = SYNC_BYTE;
    else if (idx_r == 4'h1)
      cur_tx = pid_tx;
    else if (idx_r == last)
      cur_tx = ~sum_r; // RULE_06
    else
      cur_tx = data_r[didx];
  end

  // Received bytes end at mid-stop, else a start edge right after is lost
  wire byte_end = (st_r == S_BYTE) & (bcnt_r == STOP_BIT) &
                  (tx_now ? bit_end : mid);
  wire is_data  = (idx_r >= 4'h2) & (idx_r < last);
  // Readback mismatch while driving
  wire err_bit = mid & tx_now & (rx_s_r != LIN_TX); // RULE_11
  wire err_frm = mid & (((bcnt_r == 4'h0) & rx_s_r) |
                        ((bcnt_r == STOP_BIT) & ~rx_s_r));
  wire err_syn = byte_end & (idx_r == 4'h0) & ~tx_now &
                 (rsh_r != SYNC_BYTE);
  wire err_par = byte_end & (idx_r == 4'h1) & ~cfg_mst &
                 (rsh_r[7:6] != pid_rx[7:6]); // RULE_11
  wire err_cks = byte_end & (idx_r == last) & ~tx_now &
                 (rsh_r != ~sum_r); // RULE_06
  wire err_tmo = (st_r == S_START) & bit_end &
                 (bcnt_r == TMO_BITS - 4'h1);
  wire err_any  = err_bit | err_frm | err_syn | err_par | err_cks | err_tmo;
  wire frame_ok = byte_end & (idx_r == last) & ~err_any;
  wire cap_ok   = byte_end & ~tx_now & ~err_any;
  wire sync_hit = (st_r == S_SYNC) & auto_eff & fall &
                  (falls_r == SYNC_FALLS - 3'h1);

  // Direct registers
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cfg_r <= CFG_RST;
      ptr_r <= 8'h00;
      ien_r <= 2'h0;
    end else begin
      if (wr_r && wa_r == A_CFG)
        cfg_r <= {wdat[CFG_EN], wdat[CFG_MST], wdat[CFG_AUTO]}; // RULE_04
      if (wr_r && wa_r == A_PTR)
        ptr_r <= wdat;
      if (wr_r && wa_r == A_IEN)
        ien_r <= HWDATA[1:0];
    end
  end

  // Indirect registers behind the window
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      for (int i = 0; i < 8; i++)
        data_r[i] <= 8'h00;
      size_r <= SIZE_RST;
      div_r  <= DIV_RST;
      mul_r  <= MUL_RST;
      id_r   <= 6'h00;
      txrx_r <= 1'b0;
    end else begin
      if (win_we) begin
        if (ptr_r <= I_DATA_TOP)
          data_r[ptr_r[2:0]] <= wdat; // RULE_05
        case (ptr_r)
          I_CTRL:  txrx_r <= wdat[CT_TXRX];
          I_SIZE:  size_r <= wdat;
          I_DIV:   div_r  <= wdat;
          I_MUL:   mul_r  <= wdat;
          I_ID:    id_r   <= wdat[5:0];
          default: ;
        endcase
      end
      if (cap_ok && is_data)
        data_r[didx] <= rsh_r; // RULE_10
      if (cap_ok && idx_r == 4'h1 && !cfg_mst)
        id_r <= rsh_r[5:0];
    end
  end

  // Frame engine
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st_r    <= S_IDLE;
      tmr_r   <= 24'h00_0000;
      bcnt_r  <= 4'h0;
      idx_r   <= 4'h0;
      rsh_r   <= 8'h00;
      sum_r   <= 8'h00;
      meas_r  <= 20'h0_0000;
      falls_r <= 3'h0;
    end else if (!cfg_en) begin
      st_r <= S_IDLE;
    end else begin
      case (st_r)
        S_IDLE: begin
          tmr_r  <= 24'h00_0000;
          bcnt_r <= 4'h0;
          idx_r  <= 4'h0;
          sum_r  <= 8'h00;
          if (start_wr && cfg_mst)
            st_r <= S_MBRK; // RULE_01
          else if (!cfg_mst && fall)
            st_r <= S_SBRK;
        end
        S_MBRK, S_DELIM, S_SBRK, S_START: begin
          tmr_r <= bit_end ? 24'h00_0000 : tmr_r + 24'h00_0001;
          if (bit_end && bcnt_r != 4'hF)
            bcnt_r <= bcnt_r + 4'h1;
          if (st_r == S_MBRK && bit_end && bcnt_r == BREAK_BITS - 4'h1)
            st_r <= S_DELIM; // RULE_09
          if (st_r == S_DELIM && bit_end) begin
            st_r   <= S_BYTE;
            tmr_r  <= 24'h00_0000;
            bcnt_r <= 4'h0;
          end
          if (st_r == S_SBRK && rx_s_r) begin
            st_r    <= (bcnt_r >= BRK_MIN_BITS) ? S_SYNC : S_IDLE;
            tmr_r   <= 24'h00_0000;
            bcnt_r  <= 4'h0;
            falls_r <= 3'h0;
          end
          if (st_r == S_START) begin
            if (err_tmo) begin
              st_r <= S_IDLE;
            end else if (fall) begin
              st_r   <= S_BYTE;
              tmr_r  <= 24'h00_0000;
              bcnt_r <= 4'h0;
            end
          end
        end
        S_SYNC: begin
          // Five falling edges of the sync span eight bit times
          if (!auto_eff) begin
            st_r <= S_START;
          end else if (sync_hit) begin
            meas_r <= 20'((tmr_r + 24'h00_0001) >> 3); // RULE_12
            st_r   <= S_START;
            idx_r  <= 4'h1;
            tmr_r  <= 24'h00_0000;
            bcnt_r <= 4'h0;
          end else begin
            if (fall)
              falls_r <= falls_r + 3'h1;
            if (fall && falls_r == 3'h0)
              tmr_r <= 24'h00_0000;
            else
              tmr_r <= tmr_r + 24'h00_0001;
            if (falls_r != 3'h0 && tmr_r == 24'hFF_FFFF)
              st_r <= S_IDLE;
          end
        end
        S_BYTE: begin
          tmr_r <= bit_end ? 24'h00_0000 : tmr_r + 24'h00_0001;
          if (mid && bcnt_r != 4'h0 && bcnt_r != STOP_BIT)
            rsh_r <= {rx_s_r, rsh_r[7:1]}; // RULE_09
          if (err_any) begin
            st_r <= S_IDLE;
          end else if (byte_end) begin
            if ((idx_r == 4'h1 && size_r[SZ_ENH]) || is_data)
              sum_r <= cadd(sum_r, rsh_r); // RULE_06
            bcnt_r <= 4'h0;
            tmr_r  <= 24'h00_0000;
            if (idx_r == last) begin
              st_r <= S_IDLE;
            end else begin
              idx_r <= idx_nx;
              st_r  <= tx_nx ? S_BYTE : S_START;
            end
          end else if (bit_end) begin
            bcnt_r <= bcnt_r + 4'h1;
          end
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  // Line driver: start low, stop high, data LSB first
  logic tx_nxt;
  always_comb begin
    tx_nxt = 1'b1;
    if (st_r == S_MBRK)
      tx_nxt = 1'b0;
    else if (st_r == S_BYTE && tx_now) begin
      if (bcnt_r == 4'h0)
        tx_nxt = 1'b0;
      else if (bcnt_r == STOP_BIT)
        tx_nxt = 1'b1;
      else
        tx_nxt = cur_tx[3'(bcnt_r - 4'h1)]; // RULE_09
    end
  end

  // Status flags; a new event wins over a clear in the same cycle
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      LIN_TX <= 1'b1;
      done_r <= 1'b0;
      err_r  <= 1'b0;
      errs_r <= 5'h00;
      ist_r  <= 2'h0;
      IRQ    <= 1'b0;
    end else begin
      LIN_TX <= tx_nxt;
      done_r <= frame_ok | (done_r & ~rst_int); // RULE_08
      err_r  <= err_any | (err_r & ~rst_err);
      errs_r <= {err_syn, err_tmo | err_frm, err_par, err_cks, err_bit} |
                (errs_r & {5{~rst_err}});
      ist_r  <= {err_any, frame_ok} |
                (ist_r & ~((wr_r && wa_r == A_ICLR) ? HWDATA[1:0] : 2'h0));
      IRQ    <= |(ist_r & ien_r); // RULE_08
    end
  end

  // Read mux, evaluated in the address phase
  logic [7:0] win_rd;
  always_comb begin
    win_rd = 8'h00;
    if (ptr_r <= I_DATA_TOP)
      win_rd = data_r[ptr_r[2:0]];
    case (ptr_r)
      I_CTRL:  win_rd = {2'h0, txrx_r, 5'h00};
      I_ST:    win_rd = {st_r != S_IDLE, 4'h0, err_r, 1'b0, done_r};
      I_ERR:   win_rd = {3'h0, errs_r};
      I_SIZE:  win_rd = size_r;
      I_DIV:   win_rd = div_r;
      I_MUL:   win_rd = mul_r;
      I_ID:    win_rd = {2'h0, id_r};
      default: ;
    endcase
    rdata_nxt = 32'h0000_0000;
    if (HADDR[31:8] == 24'h00_0000) begin
      case (HADDR[7:0])
        A_CFG:   rdata_nxt = {24'h00_0000, cfg_r, 4'h0, CLK_OK};
        A_PTR:   rdata_nxt = {24'h00_0000, ptr_r};
        A_WIN:   rdata_nxt = {24'h00_0000, win_rd};
        A_ISTAT: rdata_nxt = {30'h0000_0000, ist_r};
        A_IEN:   rdata_nxt = {30'h0000_0000, ien_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  sequence seq_cfg_wr;
    wr_r && wa_r == A_CFG;
  endsequence
  sequence seq_brk_run;
    (st_r == S_MBRK) [*2];
  endsequence

  chk_role_write: assert property ( // RULE_01
    seq_cfg_wr |=> cfg_mst == $past(HWDATA[CFG_MST]))
    else $error("role bit not taken from config write");
  chk_auto_write: assert property ( // RULE_02
    seq_cfg_wr |=> cfg_auto == $past(HWDATA[CFG_AUTO]))
    else $error("autobaud bit not taken from config write");
  chk_master_manual: assert property ( // RULE_03
    cfg_mst |-> st_r != S_SYNC && bl_use == bl_man)
    else $error("master not on manual baud");
  chk_window_cfg: assert property ( // RULE_04
    win_we |=> $stable(cfg_r))
    else $error("window write changed direct config");
  chk_window_target: assert property ( // RULE_05
    win_we && ptr_r == I_ID |=> id_r == $past(HWDATA[5:0]))
    else $error("window write missed pointed register");
  chk_cks_flag: assert property ( // RULE_06
    err_cks |=> errs_r[E_CKS] && err_r ##1 st_r == S_IDLE)
    else $error("checksum error not flagged");
  chk_irq_level: assert property ( // RULE_08
    frame_ok && ien_r[IS_DONE] ##1 ien_r[IS_DONE] |=> IRQ)
    else $error("enabled done did not raise interrupt");
  chk_break_low: assert property ( // RULE_09
    seq_brk_run |-> !LIN_TX)
    else $error("break not driven dominant");
  chk_rx_capture: assert property ( // RULE_10
    cap_ok && idx_r == 4'h2 && last > 4'h2 |=> data_r[0] == $past(rsh_r))
    else $error("received byte not stored");
  chk_sync_measure: assert property ( // RULE_12
    sync_hit |=> st_r == S_START && meas_r == $past(20'((tmr_r + 1) >> 3)))
    else $error("sync measure not applied");
endmodule : lcs_top
`default_nettype wire

// File: lcs_node_model.sv
`timescale 1ns/1ps
`default_nettype none
module lcs_node_model (
  input  wire logic clk,    // System clock
  input  wire logic dut_tx, // Controller drive, low dominant
  output logic      bus     // Wired-AND bus level
);
  logic drv_r = 1'b1;
  // Pull-up: a released line reads recessive
  assign bus = dut_tx & drv_r;

  task automatic send_bit(input logic v, input int len);
    drv_r <= v;
    repeat (len) @(posedge clk);
  endtask : send_bit

  // Own fixed pace, as a master node keeps a manual rate
  task automatic send_break(input int per);
    send_bit(1'b0, 13 * per);
    send_bit(1'b1, per);
  endtask : send_break

  task automatic send_byte(input logic [7:0] b, input int per);
    int i;
    send_bit(1'b0, per);
    for (i = 0; i < 8; i++) begin
      send_bit(b[i], per);
    end
    send_bit(1'b1, per);
  endtask : send_byte
endmodule : lcs_node_model
`default_nettype wire

// File: lcs_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module lcs_top_tb import lcs_pkg::*;;
  localparam int BIT = 8; // Clocks per bit: div 4, mult 0, pres 0
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hrdy, hresp, lin_tx, lin_rx, irq;
  logic        rd_ph = 1'b0;
  logic [7:0]  lf = 8'h5C;
  logic [31:0] rd_q[$];
  logic [8:0]  exp_q[$];
  int          err_count = 0;
  int          num_checks = 0;

  lcs_top DUT (
    .CLK(clk), .NRST(nrst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy),
    .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp), .LIN_RX(lin_rx),
    .LIN_TX(lin_tx), .IRQ(irq)
  );
  lcs_node_model node (.clk(clk), .dut_tx(lin_tx), .bus(lin_rx));

  initial begin
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  task automatic tmo(input string nm);
    err_count++;
    $display("wrong value %s expected response seen timeout", nm);
    end_sim();
  endtask : tmo

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  function automatic logic [7:0] pid(input logic [5:0] id);
    return {~(id[1] ^ id[3] ^ id[4] ^ id[5]),
            id[0] ^ id[1] ^ id[2] ^ id[4], id};
  endfunction : pid

  // Sum with end-around carry
  function automatic logic [7:0] csum(input logic [7:0] s, b);
    logic [8:0] t;
    t = {1'b0, s} + {1'b0, b};
    return t[7:0] + {7'h0, t[8]};
  endfunction : csum

  task automatic bus_wait();
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hrdy !== 1'b1 && k < 64);
    if (hrdy !== 1'b1) tmo("hready");
  endtask : bus_wait

  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    bus_wait();
    htrans <= 2'h0;
    hwdata <= d;
    bus_wait();
    // Idle gap: the write lands at the end of its data phase, so a read straight after already sees the new value
    if (w) @(posedge clk);
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    xfer(a, 1'b0, 32'h0);
  endtask : rd

  task automatic iwr(input logic [7:0] i, input logic [7:0] d);
    wr(A_PTR, {24'h0, i});
    wr(A_WIN, {24'h0, d});
  endtask : iwr

  task automatic ird(input logic [7:0] i, input logic [7:0] e);
    wr(A_PTR, {24'h0, i});
    rd(A_WIN, {24'h0, e});
  endtask : ird

  task automatic wait_irq();
    int k;
    for (k = 0; k < 4000 && irq !== 1'b1; k++) @(posedge clk);
    if (irq !== 1'b1) tmo("irq");
  endtask : wait_irq

  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk);
    chk("irq", {31'h0, irq}, {31'h0, e});
  endtask : irq_is

  task automatic clr();
    wr(A_ICLR, 32'h3);
    iwr(I_CTRL, 8'h0C);
  endtask : clr

  task automatic mframe(input logic enh, input logic [3:0] n,
                        input logic [5:0] id);
    logic [7:0] s;
    int i;
    s = enh ? pid(id) : 8'h00;
    iwr(I_ID, {2'h0, id});
    iwr(I_SIZE, {enh, 3'h0, n});
    exp_q.push_back(9'h100);
    exp_q.push_back({1'b0, SYNC_BYTE});
    exp_q.push_back({1'b0, pid(id)});
    for (i = 0; i < n; i++) begin
      lf = lfsr(lf);
      iwr(i[7:0], lf);
      exp_q.push_back({1'b0, lf});
      s = csum(s, lf);
    end
    ird(8'(n - 1), lf);
    exp_q.push_back({1'b0, ~s});
    iwr(I_CTRL, 8'h21);
    wait_irq();
    ird(I_ST, 8'h01);
  endtask : mframe

  task automatic sframe(input logic [5:0] id, input logic [7:0] flip);
    int p;
    p = 2 * BIT;
    lf = lfsr(lf);
    node.send_break(p);
    node.send_byte(SYNC_BYTE, p);
    node.send_byte(pid(id), p);
    node.send_byte(lf, p);
    node.send_byte(~csum(8'h00, lf) ^ flip, p);
    wait_irq();
  endtask : sframe

  always @(posedge clk) begin
    if (rd_ph) begin
      chk("hresp", {31'h0, hresp}, 32'h0);
      if (rd_q.size() == 0) chk("read queue", 32'h1, 32'h0);
      else chk("hrdata", hrdata, rd_q.pop_front());
    end
    rd_ph <= hsel & htrans[1] & ~hwrite & hrdy;
  end

  // Decodes the controller's own drive at mid-bit
  always begin : lin_mon
    int n;
    logic [9:0] sh;
    logic [8:0] got;
    @(negedge lin_tx);
    repeat (BIT / 2) @(posedge clk);
    for (n = 0; n < 10; n++) begin
      sh[n] = lin_tx;
      if (n < 9) repeat (BIT) @(posedge clk);
    end
    got = sh[9] ? {1'b0, sh[8:1]} : 9'h1FE;
    if (sh == 10'h0) begin
      n = BIT / 2 + 9 * BIT;
      while (lin_tx === 1'b0 && n < 40 * BIT) begin
        @(posedge clk);
        n++;
      end
      got = (n - 1 > 13 * BIT - BIT / 2 && n - 1 < 13 * BIT + BIT / 2) ?
            9'h100 : 9'h1FF;
    end
    if (exp_q.size() == 0) chk("lin queue", 32'h1, 32'h0);
    else chk("lin byte", {23'h0, got}, {23'h0, exp_q.pop_front()});
  end

  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(A_CFG, 32'h1);
    rd(A_IEN, 32'h0);
    rd(8'h18, 32'h0);
    wr(A_ISTAT, 32'h3);
    rd(A_ISTAT, 32'h0);
    rd(A_ICLR, 32'h0);
    wr(A_CFG, 32'hC0);
    rd(A_CFG, 32'hC1);
    iwr(I_DIV, 8'h04);
    iwr(I_MUL, 8'h00);
    ird(I_DIV, 8'h04);
    wr(A_IEN, 32'h3);
    mframe(1'b0, 4'h1, 6'h11);
    wr(A_IEN, 32'h0);
    irq_is(1'b0);
    wr(A_IEN, 32'h3);
    irq_is(1'b1);
    rd(A_ISTAT, 32'h1);
    clr();
    irq_is(1'b0);
    wr(A_CFG, 32'hE0);
    rd(A_CFG, 32'hE1);
    mframe(1'b1, 4'h8, 6'h3C);
    clr();
    wr(A_CFG, 32'hA0);
    iwr(I_SIZE, 8'h01);
    iwr(I_CTRL, 8'h01);
    repeat (40 * BIT) @(posedge clk);
    ird(I_ST, 8'h00);
    sframe(6'h2A, 8'h00);
    ird(I_ST, 8'h01);
    ird(8'h00, lf);
    ird(I_ID, 8'h2A);
    rd(A_ISTAT, 32'h1);
    clr();
    sframe(6'h15, 8'h01);
    ird(I_ERR, 8'h02);
    rd(A_ISTAT, 32'h2);
    clr();
    repeat (4) @(posedge clk);
    chk("lin left", exp_q.size(), 32'h0);
    end_sim();
  end
endmodule : lcs_top_tb
`default_nettype wire
